// [banked_sfr_register_file.sv]
// Banked control and status register file reached over the serial port.
`default_nettype none
`include "regfile_defs.svh"

module banked_sfr_register_file
  import regfile_pkg::*;
(
  input  wire logic                            clk_in,
  input  wire logic                            rst_n_in,
  input  wire spi_pins_t                       spi_in,
  input  wire logic                            pwr_down_in,
  input  wire logic [`STATUS_W-1:0]            status_in,
  input  wire logic [`DATA_W-1:0]              flag_status_in,
  output logic                                 sdo_out,
  output logic                                 sdo_oe_out,
  output logic                                 bank_choice_out,
  output logic                                 por_flag_out,
  output logic      [`COMMON_N*`DATA_W-1:0]    common_regs_out,
  output logic      [`BANK_N*`DATA_W-1:0]      bank0_regs_out,
  output logic      [`BANK_N*`DATA_W-1:0]      bank1_regs_out
);

  function automatic logic is_banked(input logic [`ADDR_W-1:0] a);
    return (a >= `BANK_FIRST) && (a <= `BANK_LAST);
  endfunction : is_banked

  function automatic logic is_status(input logic [`ADDR_W-1:0] a);
    return (a == `FLAG_REG_ADDR) || ((a >= `STATUS_FIRST) && (a <= `STATUS_LAST));
  endfunction : is_status

  function automatic logic [`BANK_IDX_W-1:0] bank_index(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] diff;
    diff = a - `BANK_FIRST;
    return diff[`BANK_IDX_W-1:0];
  endfunction : bank_index

  // Bits that exist in each register; everything else is dropped on write.
  function automatic logic [`DATA_W-1:0] impl_mask(input logic [`ADDR_W-1:0] a);
    logic [`DATA_W-1:0] m;
    m = `FULL_MASK;
    if (a == `BANK_SEL_ADDR)
    begin
      m = `BANK_SEL_MASK;
    end
    else if (a == `RESV_ADDR)
    begin
      m = `RESV_MASK;
    end
    return m;
  endfunction : impl_mask

  reg_access_t          acc;
  logic [`ADDR_W-1:0]   rd_addr;
  logic                 rd_take;
  logic [`DATA_W-1:0]   rd_data;
  logic [`DATA_W-1:0]   bank0_rd, bank1_rd;
  logic                 wr_ok, wr_bank0, wr_bank1;
  logic [`DATA_W-1:0]   wr_data;

  logic [`DATA_W-1:0]   common_q [`COMMON_N];
  logic [`DATA_W-1:0]   common_d [`COMMON_N];
  logic [`DATA_W-1:0]   bank_sel_q, bank_sel_d;
  logic                 por_q, por_d;

  spi_frame_slave u_spi (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .pins_in     (spi_in),
    .rd_data_in  (rd_data),
    .rd_addr_out (rd_addr),
    .rd_take_out (rd_take),
    .acc_out     (acc),
    .sdo_out     (sdo_out),
    .sdo_oe_out  (sdo_oe_out)
  );

  // Power-down freezes every control register by refusing writes.
  assign wr_ok    = acc.valid && acc.write && !pwr_down_in && !is_status(acc.addr);
  assign wr_data  = acc.data & impl_mask(acc.addr);
  assign wr_bank0 = wr_ok && is_banked(acc.addr) && !bank_sel_q[`BANK_SEL_BIT];
  assign wr_bank1 = wr_ok && is_banked(acc.addr) && bank_sel_q[`BANK_SEL_BIT];

  bank_store u_bank0 (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .wr_en_in    (wr_bank0),
    .wr_idx_in   (bank_index(acc.addr)),
    .wr_data_in  (wr_data),
    .rd_idx_in   (bank_index(rd_addr)),
    .rd_data_out (bank0_rd),
    .regs_out    (bank0_regs_out)
  );

  bank_store u_bank1 (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .wr_en_in    (wr_bank1),
    .wr_idx_in   (bank_index(acc.addr)),
    .wr_data_in  (wr_data),
    .rd_idx_in   (bank_index(rd_addr)),
    .rd_data_out (bank1_rd),
    .regs_out    (bank1_regs_out)
  );

  // Common region and the bank selector, visible in both banks.
  always_comb
  begin
    common_d   = common_q;
    bank_sel_d = bank_sel_q;
    if (wr_ok && (acc.addr <= `COMMON_LAST))
    begin
      common_d[acc.addr] = wr_data;
    end
    if (wr_ok && (acc.addr == `BANK_SEL_ADDR))
    begin
      bank_sel_d = wr_data;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `COMMON_N; i++)
      begin
        common_q[i] <= `CTRL_RST;
      end
      bank_sel_q <= `BANK_SEL_RST;
    end
    else
    begin
      common_q   <= common_d;
      bank_sel_q <= bank_sel_d;
    end
  end

  // Power-on flag: raised by reset, cleared when the host reads the flag register.
  always_comb
  begin
    por_d = por_q;
    if (rd_take && (rd_addr == `FLAG_REG_ADDR))
    begin
      por_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      por_q <= `POR_RST;
    end
    else
    begin
      por_q <= por_d;
    end
  end

  // Status bytes are taken live at the instant the read byte is loaded.
  always_comb
  begin
    rd_data = `CTRL_RST;
    if (rd_addr == `FLAG_REG_ADDR)
    begin
      rd_data = flag_status_in;
      rd_data[`FLAG_POR_BIT] = por_q;
    end
    else if (is_status(rd_addr))
    begin
      rd_data = status_in[(rd_addr - `STATUS_FIRST)*`DATA_W +: `DATA_W];
    end
    else if (rd_addr == `BANK_SEL_ADDR)
    begin
      rd_data = bank_sel_q & impl_mask(rd_addr);
    end
    else if (is_banked(rd_addr))
    begin
      rd_data = bank_sel_q[`BANK_SEL_BIT] ? bank1_rd : bank0_rd;
    end
    else
    begin
      rd_data = common_q[rd_addr];
    end
  end

  always_comb
  begin
    for (int i = 0; i < `COMMON_N; i++)
    begin
      common_regs_out[i*`DATA_W +: `DATA_W] = common_q[i];
    end
  end

  assign bank_choice_out = bank_sel_q[`BANK_SEL_BIT];
  assign por_flag_out    = por_q;

  sequence s_bank_write_sel0;
    acc.valid && acc.write && is_banked(acc.addr) && !bank_sel_q[`BANK_SEL_BIT];
  endsequence

  sequence s_bank_write_sel1;
    acc.valid && acc.write && is_banked(acc.addr) && bank_sel_q[`BANK_SEL_BIT];
  endsequence

  a_bank1_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_bank_write_sel0 |=> $stable(bank1_regs_out))
    else $error("bank one changed by a bank zero write");

  a_bank0_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_bank_write_sel1 |=> $stable(bank0_regs_out))
    else $error("bank zero changed by a bank one write");

  a_bank_sel_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (acc.valid && acc.write && !pwr_down_in && (acc.addr == `BANK_SEL_ADDR))
    |=> (bank_choice_out == $past(acc.data[0])))
    else $error("bank selector not updated by write");

  a_unimpl_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    bank_sel_q[7:1] == 7'h00)
    else $error("unimplemented selector bits hold ones");

  a_status_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (acc.valid && acc.write && (acc.addr == `STATUS_FIRST)) |=> $stable(common_q[42]))
    else $error("status write changed storage");

  a_pd_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pwr_down_in |=> $stable(bank_sel_q) && $stable(bank0_regs_out) && $stable(bank1_regs_out)
                    && $stable(common_regs_out))
    else $error("control register changed in power-down");

  a_status_live: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_addr == `STATUS_FIRST) |-> (rd_data == status_in[7:0]))
    else $error("status read not live");

  a_por_defaults: assert property (@(posedge clk_in) disable iff (1'b0)
    !rst_n_in |=> (por_flag_out && !bank_choice_out && (common_regs_out == '0)))
    else $error("defaults not loaded by reset");

  a_window_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    is_banked(rd_addr) |-> (rd_data == (bank_choice_out ? bank1_rd : bank0_rd)))
    else $error("banked read from wrong array");

  sequence s_flag_read;
    rd_take && (rd_addr == `FLAG_REG_ADDR);
  endsequence

  a_por_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_flag_read |=> !por_flag_out)
    else $error("power-on flag not cleared by a flag read");

  // Only reset may raise the flag again, so a cleared flag stays cleared.
  a_por_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !por_flag_out |=> !por_flag_out)
    else $error("power-on flag raised without reset");

  a_flag_write_void: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (acc.valid && acc.write && (acc.addr == `FLAG_REG_ADDR))
    |=> $stable(por_flag_out) && $stable(common_q[`FLAG_REG_ADDR]))
    else $error("flag register write changed state");

  a_sel_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(acc.valid && acc.write && (acc.addr == `BANK_SEL_ADDR)) |=> $stable(bank_choice_out))
    else $error("bank choice changed without a selector write");

  a_common_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (acc.valid && acc.write && !pwr_down_in && (acc.addr == `COMMON_FIRST))
    |=> (common_q[`COMMON_FIRST] == $past(acc.data)))
    else $error("control write not stored");

  a_resv_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (acc.valid && acc.write && !pwr_down_in && (acc.addr == `RESV_ADDR))
    |=> (common_q[`RESV_ADDR] == $past(acc.data)))
    else $error("reserved bits not stored");

  a_bank0_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (acc.valid && acc.write && !pwr_down_in && (acc.addr == `BANK_FIRST) && !bank_choice_out)
    |=> (bank0_regs_out[`DATA_W-1:0] == $past(acc.data)))
    else $error("bank zero write not stored");

  a_bank1_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (acc.valid && acc.write && !pwr_down_in && (acc.addr == `BANK_FIRST) && bank_choice_out)
    |=> (bank1_regs_out[`DATA_W-1:0] == $past(acc.data)))
    else $error("bank one write not stored");

  a_sel_read_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_addr == `BANK_SEL_ADDR) |-> (rd_data == {7'h00, bank_choice_out}))
    else $error("selector read shows unimplemented bits");

  a_status_last: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_addr == `STATUS_LAST) |-> (rd_data == status_in[`STATUS_W-1:`STATUS_W-`DATA_W]))
    else $error("last status byte not live");

  a_flag_live: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_addr == `FLAG_REG_ADDR) |-> (rd_data == {flag_status_in[`DATA_W-1:1], por_flag_out}))
    else $error("flag register read not live");

endmodule : banked_sfr_register_file

`default_nettype wire

// [regfile_defs.svh]
// Address map, field positions, reset values and frame counts of the register file.
`ifndef REGFILE_DEFS_SVH
`define REGFILE_DEFS_SVH

`define ADDR_W          6
`define DATA_W          8
`define COMMON_FIRST    6'h00
`define COMMON_LAST     6'h2d
`define BANK_FIRST      6'h2e
`define BANK_LAST       6'h3e
`define BANK_SEL_ADDR   6'h3f
`define FLAG_REG_ADDR   6'h15
`define STATUS_FIRST    6'h2a
`define STATUS_LAST     6'h2d
`define RESV_ADDR       6'h12
`define COMMON_N        46
`define BANK_N          17
`define BANK_IDX_W      5
`define BANK_SEL_BIT    0
`define BANK_SEL_MASK   8'h01
`define RESV_MASK       8'hff
`define FULL_MASK       8'hff
`define CTRL_RST        8'h00
`define BANK_SEL_RST    8'h00
`define POR_RST         1'b1
`define FLAG_POR_BIT    0
`define CMD_WRITE_BIT   7
`define CMD_BITS        5'h08
`define FRAME_LAST_BIT  5'h0f
`define STATUS_W        32

`endif

// [regfile_pkg.sv]
// Types shared by the register file and its serial front end.
`default_nettype none
`include "regfile_defs.svh"

package regfile_pkg;

  typedef struct packed {
    logic                 sclk;
    logic                 cs_n;
    logic                 sdi;
  } spi_pins_t;

  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   data;
  } reg_access_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_DATA = 2'b10,
    ST_DONE = 2'b11
  } spi_state_t;

endpackage : regfile_pkg

`default_nettype wire

// [bank_store.sv]
// One bank of the switched window: 17 byte registers with a single write port.
`default_nettype none
`include "regfile_defs.svh"

module bank_store
  import regfile_pkg::*;
(
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        wr_en_in,
  input  wire logic [`BANK_IDX_W-1:0]      wr_idx_in,
  input  wire logic [`DATA_W-1:0]          wr_data_in,
  input  wire logic [`BANK_IDX_W-1:0]      rd_idx_in,
  output logic      [`DATA_W-1:0]          rd_data_out,
  output logic      [`BANK_N*`DATA_W-1:0]  regs_out
);

  logic [`DATA_W-1:0] mem_q [`BANK_N];
  logic [`DATA_W-1:0] mem_d [`BANK_N];

  always_comb
  begin
    mem_d = mem_q;
    if (wr_en_in && (wr_idx_in < `BANK_IDX_W'(`BANK_N)))
    begin
      mem_d[wr_idx_in] = wr_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `BANK_N; i++)
      begin
        mem_q[i] <= `CTRL_RST;
      end
    end
    else
    begin
      mem_q <= mem_d;
    end
  end

  always_comb
  begin
    rd_data_out = `CTRL_RST;
    if (rd_idx_in < `BANK_IDX_W'(`BANK_N))
    begin
      rd_data_out = mem_q[rd_idx_in];
    end
    for (int i = 0; i < `BANK_N; i++)
    begin
      regs_out[i*`DATA_W +: `DATA_W] = mem_q[i];
    end
  end

endmodule : bank_store

`default_nettype wire

// [spi_frame_slave.sv]
// Serial front end: command byte then data byte, mode 0, one register per frame.
`default_nettype none
`include "regfile_defs.svh"

module spi_frame_slave
  import regfile_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire spi_pins_t            pins_in,
  input  wire logic [`DATA_W-1:0]   rd_data_in,
  output logic      [`ADDR_W-1:0]   rd_addr_out,
  output logic                      rd_take_out,
  output reg_access_t               acc_out,
  output logic                      sdo_out,
  output logic                      sdo_oe_out
);

  spi_state_t          state_q, state_d;
  logic [4:0]          cnt_q, cnt_d;
  logic                sclk_q;
  logic [15:0]         shin_q, shin_d;
  logic [`DATA_W-1:0]  shout_q, shout_d;
  logic                sdo_q, sdo_d, oe_q, oe_d, take_q, take_d;
  reg_access_t         acc_q, acc_d;
  logic                rise, fall;
  logic                wr_cmd;

  assign rise        = pins_in.sclk & ~sclk_q;
  assign fall        = ~pins_in.sclk & sclk_q;
  assign rd_addr_out = shin_q[`ADDR_W-1:0];
  // The write flag climbs the shift register as data bits arrive, so the count locates it.
  assign wr_cmd      = shin_q[4'(cnt_q - 5'h01)];

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shin_d  = shin_q;
    shout_d = shout_q;
    sdo_d   = sdo_q;
    oe_d    = oe_q;
    take_d  = 1'b0;
    acc_d   = '0;
    if (pins_in.cs_n)
    begin
      state_d = ST_IDLE;
      cnt_d   = 5'h00;
      oe_d    = 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE: state_d = ST_CMD;
        ST_CMD:
        begin
          if (rise)
          begin
            shin_d = {shin_q[14:0], pins_in.sdi};
            cnt_d  = cnt_q + 5'h01;
            if (cnt_q == `CMD_BITS - 5'h01)
            begin
              state_d = ST_DATA;
            end
          end
        end
        ST_DATA:
        begin
          // The read byte is fetched on the first falling edge after the command.
          if (fall && !wr_cmd)
          begin
            if (cnt_q == `CMD_BITS)
            begin
              shout_d = rd_data_in;
              sdo_d   = rd_data_in[`DATA_W-1];
              oe_d    = 1'b1;
              take_d  = 1'b1;
            end
            else
            begin
              shout_d = {shout_q[`DATA_W-2:0], 1'b0};
              sdo_d   = shout_q[`DATA_W-2];
            end
          end
          if (rise)
          begin
            shin_d = {shin_q[14:0], pins_in.sdi};
            cnt_d  = cnt_q + 5'h01;
            if (cnt_q == `FRAME_LAST_BIT)
            begin
              state_d    = ST_DONE;
              acc_d.valid = shin_q[`CMD_WRITE_BIT+`DATA_W-1];
              acc_d.write = shin_q[`CMD_WRITE_BIT+`DATA_W-1];
              acc_d.addr  = shin_q[`DATA_W+`ADDR_W-2:`DATA_W-1];
              acc_d.data  = {shin_q[`DATA_W-2:0], pins_in.sdi};
            end
          end
        end
        ST_DONE: state_d = ST_DONE;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'h00;
      sclk_q  <= 1'b0;
      shin_q  <= 16'h0000;
      shout_q <= 8'h00;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
      take_q  <= 1'b0;
      acc_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sclk_q  <= pins_in.sclk;
      shin_q  <= shin_d;
      shout_q <= shout_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
      take_q  <= take_d;
      acc_q   <= acc_d;
    end
  end

  assign rd_take_out = take_q;
  assign acc_out     = acc_q;
  assign sdo_out     = sdo_q;
  assign sdo_oe_out  = oe_q;

  sequence s_frame_end;
    (state_q == ST_DATA) && rise && (cnt_q == `FRAME_LAST_BIT) && !pins_in.cs_n;
  endsequence

  a_frame_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_frame_end |=> (acc_q.valid == $past(shin_q[14])) && (state_q == ST_DONE))
    else $error("write access not issued at end of frame");

endmodule : spi_frame_slave

`default_nettype wire

// [host_spi_model.sv]
// Host controller model that runs one command and data frame per call on the serial port.
`default_nettype none
`include "regfile_defs.svh"

module host_spi_model
  import regfile_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      sdo_in,
  input  wire logic      sdo_oe_in,
  output var  spi_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Three clocks per serial half period keeps well clear of the two-clock minimum.
  localparam int HALF = 3;

  initial pins_out = '{1'b0, 1'b1, 1'b0};

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_clk

  // Mode 0: data is set while the clock is low and read data is taken just before each of the eight data-byte rises.
  task automatic xfer(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata, output logic oe_ok);
    logic [15:0] word;
    word = {wr, 1'b0, addr, wdata};
    rdata = 8'h00;
    oe_ok = 1'b1;
    wait_clk(1);
    pins_out.cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      pins_out.sdi = word[i];
      wait_clk(HALF);
      if (i < 8)
      begin
        rdata = {rdata[6:0], sdo_in};
        oe_ok = oe_ok & sdo_oe_in;
      end
      pins_out.sclk = 1'b1;
      wait_clk(HALF);
      pins_out.sclk = 1'b0;
    end
    wait_clk(HALF);
    pins_out.cs_n = 1'b1;
    // A deselected data line does not keep its last level, so the model turns it round.
    pins_out.sdi = ~pins_out.sdi;
    wait_clk(4);
  endtask : xfer
endmodule : host_spi_model

`default_nettype wire

// [banked_sfr_register_file_tb.sv]
// Self-checking testbench of the banked register file driven through the host model.
`default_nettype none
`include "regfile_defs.svh"

module banked_sfr_register_file_tb
  import regfile_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                         clk_in = 1'b0;
  logic                         rst_n_in = 1'b0;
  spi_pins_t                    spi;
  logic                         pwr_down_in = 1'b0;
  logic [`STATUS_W-1:0]         status_in = 32'h00000000;
  logic [`DATA_W-1:0]           flag_status_in = 8'h00;
  logic                         sdo;
  logic                         sdo_oe;
  logic                         bank_choice;
  logic                         por_flag;
  logic [`COMMON_N*`DATA_W-1:0] common_regs;
  logic [`BANK_N*`DATA_W-1:0]   bank0_regs;
  logic [`BANK_N*`DATA_W-1:0]   bank1_regs;
  int                           miscompares = 0;
  int                           n_tests = 0;
  int                           cycles = 0;

  banked_sfr_register_file i_banked_sfr_register_file (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .spi_in          (spi),
    .pwr_down_in     (pwr_down_in),
    .status_in       (status_in),
    .flag_status_in  (flag_status_in),
    .sdo_out         (sdo),
    .sdo_oe_out      (sdo_oe),
    .bank_choice_out (bank_choice),
    .por_flag_out    (por_flag),
    .common_regs_out (common_regs),
    .bank0_regs_out  (bank0_regs),
    .bank1_regs_out  (bank1_regs)
  );

  host_spi_model i_host_spi_model (
    .clk_in    (clk_in),
    .sdo_in    (sdo),
    .sdo_oe_in (sdo_oe),
    .pins_out  (spi)
  );

  initial
  begin
    forever #20 clk_in = ~clk_in;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // About thirty frames of roughly a hundred clocks each; the ceiling leaves ample room.
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       ok;
    i_host_spi_model.xfer(1'b1, a, d, r, ok);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       ok;
    i_host_spi_model.xfer(1'b0, a, 8'h00, r, ok);
    check({7'h00, ok}, 8'h01);
    check(r, exp);
  endtask : rd

  task automatic t_defaults();
    check({7'h00, por_flag}, 8'h01);
    check({7'h00, bank_choice}, 8'h00);
    rd(6'h3f, 8'h00);
    rd(6'h00, 8'h00);
    $display("defaults done");
  endtask : t_defaults

  task automatic t_common();
    wr(6'h00, 8'ha5);
    rd(6'h00, 8'ha5);
    check(common_regs[7:0], 8'ha5);
    status_in = 32'h005c0000;
    wr(6'h2c, 8'hff);
    rd(6'h2c, 8'h5c);
    check(common_regs[8*44 +: 8], 8'h00);
    $display("common done");
  endtask : t_common

  task automatic t_banks();
    wr(6'h2e, 8'h11);
    wr(6'h3e, 8'h22);
    wr(6'h3f, 8'hff);
    rd(6'h3f, 8'h01);
    check({7'h00, bank_choice}, 8'h01);
    wr(6'h2e, 8'h33);
    rd(6'h2e, 8'h33);
    rd(6'h3e, 8'h00);
    check(bank0_regs[7:0], 8'h11);
    rd(6'h00, 8'ha5);
    wr(6'h3f, 8'h00);
    rd(6'h2e, 8'h11);
    rd(6'h3e, 8'h22);
    check(bank1_regs[7:0], 8'h33);
    $display("banks done");
  endtask : t_banks

  task automatic t_status();
    status_in = 32'h44332211;
    rd(6'h2a, 8'h11);
    rd(6'h2d, 8'h44);
    status_in = 32'h00000088;
    rd(6'h2a, 8'h88);
    flag_status_in = 8'hf0;
    rd(6'h15, 8'hf1);
    check({7'h00, por_flag}, 8'h00);
    wr(6'h15, 8'hff);
    rd(6'h15, 8'hf0);
    $display("status done");
  endtask : t_status

  task automatic t_reserved();
    wr(6'h12, 8'hff);
    rd(6'h12, 8'hff);
    check(common_regs[8*18 +: 8], 8'hff);
    $display("reserved done");
  endtask : t_reserved

  task automatic t_power_down();
    pwr_down_in = 1'b1;
    wr(6'h00, 8'h5a);
    wr(6'h2e, 8'h77);
    pwr_down_in = 1'b0;
    rd(6'h00, 8'ha5);
    rd(6'h2e, 8'h11);
    $display("power down done");
  endtask : t_power_down

  task automatic t_second_reset();
    wr(6'h3f, 8'h01);
    check({7'h00, bank_choice}, 8'h01);
    @(posedge clk_in);
    #1;
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    check({7'h00, por_flag}, 8'h01);
    check({7'h00, bank_choice}, 8'h00);
    rd(6'h00, 8'h00);
    rd(6'h2e, 8'h00);
    $display("second reset done");
  endtask : t_second_reset

  initial
  begin
    repeat (5) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    t_defaults();
    t_common();
    t_banks();
    t_status();
    t_reserved();
    t_power_down();
    t_second_reset();
    end_of_test();
  end
endmodule : banked_sfr_register_file_tb

`default_nettype wire
